//--- rtl/sfc_cmd_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module sfc_cmd_ctrl #(
	parameter int ADDR_W = sfc_pkg::ADDR_W
) (
	input  wire logic              clk_i,
	input  wire logic              resetn_i,
	input  wire logic              sck_i,
	input  wire logic              cs_n_i,
	input  wire logic [3:0]        sio_i,
	output logic      [3:0]        sio_o,
	output logic      [3:0]        sio_oe_n_o,
	output logic      [ADDR_W-1:0] rd_addr_o,
	input  wire logic [7:0]        rd_data_i,
	output logic                   quad_mode_o,
	output logic                   cont_mode_o,
	output logic      [1:0]        burst_len_o,
	input  wire logic              busy_i,
	input  wire logic              stat_wr_i,
	input  wire logic [7:0]        stat_wdata_i,
	input  wire logic              cfg_wr_i,
	input  wire logic [7:0]        cfg_wdata_i,
	output logic      [7:0]        status_o,
	output logic      [7:0]        config_o,
	output logic                   ready_o,
	output logic                   abort_o,
	output logic                   erase_req_o,
	output sfc_pkg::sfc_erase_t    erase_o
);
	localparam int RW_DLY = sfc_pkg::RST_WRITE_CYC + 1;

	// Frame decode table
	function automatic sfc_pkg::sfc_frame_t frame_of(input logic [7:0] op, input logic quad);
		sfc_pkg::sfc_frame_t f;
		sfc_pkg::sfc_lanes_t cl;
		cl = quad ? sfc_pkg::LW4 : sfc_pkg::LW1;
		f = '{rd: 1'b0, er: 1'b0, addr_lw: cl, data_lw: cl, has_mode: 1'b0, dummy_bits: 5'h00};
		case (op)
			sfc_pkg::READ_CMD: f.rd = !quad;
			sfc_pkg::FAST_READ_CMD: begin
				f.rd = 1'b1;
				f.has_mode = quad;
				f.dummy_bits = quad ? 5'(sfc_pkg::FQ_DUMMY) : 5'(sfc_pkg::SP_DUMMY);
			end
			sfc_pkg::DUAL_OUT_CMD: begin
				f.rd = !quad;
				f.data_lw = sfc_pkg::LW2;
				f.dummy_bits = 5'(sfc_pkg::SP_DUMMY);
			end
			sfc_pkg::DUAL_IO_CMD: begin
				f.rd = !quad;
				f.addr_lw = sfc_pkg::LW2;
				f.data_lw = sfc_pkg::LW2;
				f.has_mode = 1'b1;
			end
			sfc_pkg::SECT_ERASE_CMD, sfc_pkg::BLK_ERASE_CMD: f.er = 1'b1;
			default: f.rd = 1'b0;
		endcase
		return f;
	endfunction

	// Erase base address for the granule at that location
	function automatic logic [23:0] erase_base(input sfc_pkg::sfc_erase_t e);
		logic [23:0] a;
		logic        hi1;
		logic        hi0;
		int          lsb;
		a = e.addr & 24'((64'h1 << ADDR_W) - 1);
		hi1 = &a[ADDR_W-1:sfc_pkg::BLK64_LSB];
		hi0 = ~|a[ADDR_W-1:sfc_pkg::BLK64_LSB];
		if (e.kind == sfc_pkg::ER_SECTOR)
			lsb = sfc_pkg::SECTOR_LSB;
		else if ((hi1 || hi0) && (a[sfc_pkg::BLK32_LSB] == hi1))
			lsb = sfc_pkg::BLK8_LSB;
		else if (hi1 || hi0)
			lsb = sfc_pkg::BLK32_LSB;
		else
			lsb = sfc_pkg::BLK64_LSB;
		return a & ~((24'h1 << lsb) - 24'h1);
	endfunction

	// Link domain state
	sfc_pkg::sfc_state_t st_q, st_d;
	sfc_pkg::sfc_frame_t frm_q, frm_d, dec;
	sfc_pkg::sfc_lanes_t lw;
	sfc_pkg::sfc_erase_t er_q;
	logic [4:0]        cnt_q, cnt_d, tgt;
	logic [23:0]       sh_q, sh_d;
	logic [7:0]        op_q;
	logic [2:0]        pos_q, lanes;
	logic [5:0]        edges_q;
	logic [ADDR_W-1:0] rd_addr_q;
	logic              quad_q, arm_q, cont_q;
	logic [1:0]        burst_q;
	logic              er_tgl_q, rs_tgl_q;
	logic [3:0]        out_q, oe_n_q, out_d, oe_d;
	logic [7:0]        byte_in, sh_out;
	logic              frame_rst, done, opc_done, cont_head, rst_go, byte_end;

	// Frame ends on chip select rise; persistent state survives
	assign frame_rst = cs_n_i | ~resetn_i;
	assign dec = frame_of(byte_in, quad_q);
	assign lanes = (lw == sfc_pkg::LW4) ? 3'd4 : (lw == sfc_pkg::LW2) ? 3'd2 : 3'd1;

	// Lanes and length of the current phase
	assign lw = (st_q == sfc_pkg::S_OPC) ? (quad_q ? sfc_pkg::LW4 : sfc_pkg::LW1)
		: (st_q == sfc_pkg::S_DOUT || st_q == sfc_pkg::S_DIN) ? frm_q.data_lw
		: frm_q.addr_lw;
	assign tgt = (st_q == sfc_pkg::S_OPC) ? 5'(sfc_pkg::OPC_BITS)
		: (st_q == sfc_pkg::S_ADDR) ? 5'(sfc_pkg::ADDR_BITS)
		: (st_q == sfc_pkg::S_MODE) ? 5'(sfc_pkg::MODE_BITS)
		: (st_q == sfc_pkg::S_DUMMY) ? frm_q.dummy_bits : 5'(sfc_pkg::BYTE_BITS);

	// Input shift, upper lines ignored in single wire
	assign sh_d = (lw == sfc_pkg::LW4) ? {sh_q[19:0], sio_i}
		: (lw == sfc_pkg::LW2) ? {sh_q[21:0], sio_i[1:0]} : {sh_q[22:0], sio_i[0]};
	assign byte_in = sh_d[7:0];
	assign done = (cnt_q + 5'(lanes)) == tgt;
	assign opc_done = (st_q == sfc_pkg::S_OPC) && done && !cont_q;
	assign cont_head = (st_q == sfc_pkg::S_OPC) && done && cont_q;
	assign rst_go = opc_done && (byte_in == sfc_pkg::RESET_CMD) && arm_q;
	assign byte_end = (st_q == sfc_pkg::S_DOUT) && ((pos_q + lanes) == 3'd0);
	assign cnt_d = !done ? cnt_q + 5'(lanes) : cont_head ? 5'(sfc_pkg::OPC_BITS) : 5'h00;

	// Phase sequencing
	always_comb begin
		st_d = st_q;
		frm_d = frm_q;
		case (st_q)
			sfc_pkg::S_OPC: begin
				if (cont_head && byte_in == sfc_pkg::quad_exit_cmd) begin
					st_d = sfc_pkg::S_IGNORE;
				end else if (cont_head) begin
					st_d = sfc_pkg::S_ADDR;
					frm_d = frame_of(sfc_pkg::FAST_READ_CMD, 1'b1);
				end else if (opc_done) begin
					frm_d = dec;
					st_d = (dec.rd || dec.er) ? sfc_pkg::S_ADDR
						: (byte_in == sfc_pkg::SET_BURST_CMD) ? sfc_pkg::S_DIN : sfc_pkg::S_IGNORE;
				end
			end
			sfc_pkg::S_ADDR: begin
				if (done && frm_q.er)
					st_d = sfc_pkg::S_IGNORE;
				else if (done)
					st_d = frm_q.has_mode ? sfc_pkg::S_MODE
						: (frm_q.dummy_bits != 5'h00) ? sfc_pkg::S_DUMMY : sfc_pkg::S_DOUT;
			end
			sfc_pkg::S_MODE: begin
				if (done)
					st_d = (frm_q.dummy_bits != 5'h00) ? sfc_pkg::S_DUMMY : sfc_pkg::S_DOUT;
			end
			sfc_pkg::S_DUMMY: begin
				if (done)
					st_d = sfc_pkg::S_DOUT;
			end
			sfc_pkg::S_DIN: begin
				if (done)
					st_d = sfc_pkg::S_IGNORE;
			end
			default: st_d = st_q;
		endcase
	end

	// Per-frame registers, cleared while chip select is high
	always_ff @(posedge sck_i or posedge frame_rst) begin
		if (frame_rst) begin
			st_q <= sfc_pkg::S_OPC;
			frm_q <= '0;
			cnt_q <= 5'h00;
			sh_q <= 24'h000000;
			op_q <= 8'h00;
			pos_q <= 3'd0;
			edges_q <= 6'h00;
		end else begin
			st_q <= st_d;
			frm_q <= frm_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			op_q <= opc_done ? byte_in : op_q;
			pos_q <= (st_q == sfc_pkg::S_DOUT) ? pos_q + lanes : 3'd0;
			edges_q <= (edges_q == 6'h3f) ? edges_q : edges_q + 6'h01;
		end
	end

	// Read address: loaded without upper bits, then streams and wraps
	always_ff @(posedge sck_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rd_addr_q <= '0;
		end else if (st_q == sfc_pkg::S_ADDR && done && frm_q.rd) begin
			rd_addr_q <= sh_d[ADDR_W-1:0];
		end else if (byte_end) begin
			rd_addr_q <= rd_addr_q + 1'b1;
		end
	end

	// Mode state that outlives a frame
	always_ff @(posedge sck_i or negedge resetn_i) begin
		if (!resetn_i) begin
			quad_q <= 1'b0;
			arm_q <= 1'b0;
			cont_q <= 1'b0;
			burst_q <= sfc_pkg::BURST_RST;
			rs_tgl_q <= 1'b0;
		end else begin
			if (opc_done || cont_head)
				arm_q <= opc_done && (byte_in == sfc_pkg::reset_arm_cmd);
			if (rst_go) begin
				quad_q <= 1'b0;
				cont_q <= 1'b0;
				burst_q <= sfc_pkg::BURST_RST;
				rs_tgl_q <= ~rs_tgl_q;
			end else if (opc_done && byte_in == sfc_pkg::quad_enter_cmd && !quad_q) begin
				quad_q <= 1'b1;
			end else if (opc_done && byte_in == sfc_pkg::quad_exit_cmd) begin
				quad_q <= 1'b0;
			end else if (cont_head && byte_in == sfc_pkg::quad_exit_cmd) begin
				cont_q <= 1'b0;
			end else if (st_q == sfc_pkg::S_MODE && done && frm_q.addr_lw == sfc_pkg::LW4) begin
				cont_q <= byte_in[7:4] == sfc_pkg::CONT_NIBBLE;
			end else if (st_q == sfc_pkg::S_DIN && done) begin
				burst_q <= byte_in[1:0];
			end
		end
	end

	// Erase word, held steady until the next erase toggle
	always_ff @(posedge sck_i or negedge resetn_i) begin
		if (!resetn_i) begin
			er_q <= '0;
			er_tgl_q <= 1'b0;
		end else if (st_q == sfc_pkg::S_ADDR && done && frm_q.er) begin
			er_q.kind <= (op_q == sfc_pkg::SECT_ERASE_CMD) ? sfc_pkg::ER_SECTOR : sfc_pkg::ER_BLOCK;
			er_q.addr <= sh_d;
			er_tgl_q <= ~er_tgl_q;
		end
	end

	// Output lanes, launched on the falling serial clock edge
	assign sh_out = 8'(rd_data_i << pos_q);
	assign out_d = (frm_q.data_lw == sfc_pkg::LW4) ? sh_out[7:4]
		: (frm_q.data_lw == sfc_pkg::LW2) ? {2'b00, sh_out[7:6]} : {2'b00, sh_out[7], 1'b0};
	assign oe_d = (st_q != sfc_pkg::S_DOUT) ? 4'hf
		: (frm_q.data_lw == sfc_pkg::LW4) ? 4'h0
		: (frm_q.data_lw == sfc_pkg::LW2) ? 4'hc : 4'hd;
	always_ff @(negedge sck_i or posedge frame_rst) begin
		if (frame_rst) begin
			out_q <= 4'h0;
			oe_n_q <= 4'hf;
		end else begin
			out_q <= out_d;
			oe_n_q <= oe_d;
		end
	end

	assign sio_o = out_q;
	assign sio_oe_n_o = oe_n_q;
	assign rd_addr_o = rd_addr_q;
	assign quad_mode_o = quad_q;
	assign cont_mode_o = cont_q;
	assign burst_len_o = burst_q;

	// Core domain: events arrive as synchronised toggles
	logic [1:0] tgl_s;
	logic [1:0] seen_q;
	logic       er_evt, rs_evt;
	logic [7:0] status_q, status_d, config_q, config_d;
	logic [7:0] recov_q;
	logic       abort_q, ereq_q;
	sfc_pkg::sfc_erase_t erase_q;

	sfc_sync #(
		.W(2)
	) u_sync (
		.clk_i   (clk_i),
		.resetn_i(resetn_i),
		.d_i     ({er_tgl_q, rs_tgl_q}),
		.q_o     (tgl_s)
	);

	assign er_evt = tgl_s[1] ^ seen_q[1];
	assign rs_evt = tgl_s[0] ^ seen_q[0];
	// Reset keeps lock bits, clears io config
	assign status_d = rs_evt ? ((status_q & sfc_pkg::STAT_KEEP) | (sfc_pkg::STAT_RST & ~sfc_pkg::STAT_KEEP))
		: stat_wr_i ? stat_wdata_i : status_q;
	assign config_d = rs_evt ? ((config_q & ~sfc_pkg::CFG_MASK) | (sfc_pkg::CFG_RST & sfc_pkg::CFG_MASK))
		: cfg_wr_i ? cfg_wdata_i : config_q;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			seen_q <= 2'b00;
			status_q <= sfc_pkg::STAT_RST;
			config_q <= sfc_pkg::CFG_RST;
			recov_q <= 8'h00;
			abort_q <= 1'b0;
			ereq_q <= 1'b0;
			erase_q <= '0;
		end else begin
			seen_q <= tgl_s;
			status_q <= status_d;
			config_q <= config_d;
			abort_q <= rs_evt && busy_i;
			if (rs_evt)
				recov_q <= busy_i ? 8'(sfc_pkg::RST_WRITE_CYC) : 8'(sfc_pkg::RST_OTHER_CYC);
			else if (recov_q != 8'h00)
				recov_q <= recov_q - 8'h01;
			ereq_q <= er_evt;
			if (er_evt)
				erase_q <= '{kind: er_q.kind, addr: erase_base(er_q)};
		end
	end

	assign status_o = status_q;
	assign config_o = config_q;
	assign ready_o = (recov_q == 8'h00);
	assign abort_o = abort_q;
	assign erase_req_o = ereq_q;
	assign erase_o = erase_q;

	// Link checks
	a_opc_length: assert property (@(posedge sck_i) disable iff (frame_rst)
		opc_done |-> edges_q == (quad_q ? 6'd1 : 6'd7)) else $error("opcode length wrong");
	a_read_framing: assert property (@(posedge sck_i) disable iff (frame_rst)
		(st_q == sfc_pkg::S_ADDR && done && op_q == sfc_pkg::READ_CMD)
		|-> (edges_q == 6'd31) ##1 (st_q == sfc_pkg::S_DOUT)) else $error("read framing wrong");
	a_quad_byte_time: assert property (@(posedge sck_i) disable iff (frame_rst)
		(st_q == sfc_pkg::S_DOUT && frm_q.data_lw == sfc_pkg::LW4 && pos_q == 3'd0)
		|=> pos_q == 3'd4 ##1 pos_q == 3'd0) else $error("quad byte not two clocks");
	a_dual_byte_time: assert property (@(posedge sck_i) disable iff (frame_rst)
		(st_q == sfc_pkg::S_DOUT && frm_q.data_lw == sfc_pkg::LW2 && pos_q == 3'd0)
		|=> pos_q == 3'd2 ##1 pos_q == 3'd4 ##1 pos_q == 3'd6 ##1 pos_q == 3'd0)
		else $error("dual byte not four clocks");
	a_addr_wrap: assert property (@(posedge sck_i) disable iff (frame_rst)
		byte_end |=> rd_addr_q == $past(rd_addr_q) + 1'b1) else $error("address not stepped");
	// Persistent mode checks; the first five span the frame boundary, so only reset disables them
	a_arm_follow: assert property (@(posedge sck_i) disable iff (!resetn_i)
		opc_done |=> arm_q == ($past(byte_in) == sfc_pkg::reset_arm_cmd)) else $error("arming wrong");
	a_reset_unarmed: assert property (@(posedge sck_i) disable iff (!resetn_i)
		(opc_done && byte_in == sfc_pkg::RESET_CMD && !arm_q) |=> $stable(rs_tgl_q))
		else $error("reset ran unarmed");
	a_quad_enter: assert property (@(posedge sck_i) disable iff (!resetn_i)
		(opc_done && byte_in == sfc_pkg::quad_enter_cmd) |=> quad_q) else $error("quad not entered");
	a_quad_exit: assert property (@(posedge sck_i) disable iff (!resetn_i)
		(opc_done && byte_in == sfc_pkg::quad_exit_cmd) |=> !quad_q) else $error("quad not left");
	a_cont_exit: assert property (@(posedge sck_i) disable iff (!resetn_i)
		(cont_head && byte_in == sfc_pkg::quad_exit_cmd) |=> !cont_q && quad_q)
		else $error("continuation exit wrong");
	a_read_single: assert property (@(posedge sck_i) disable iff (frame_rst)
		(opc_done && quad_q && byte_in == sfc_pkg::READ_CMD) |=> st_q == sfc_pkg::S_IGNORE)
		else $error("basic read taken in quad");
	a_mode_cont: assert property (@(posedge sck_i) disable iff (frame_rst)
		(st_q == sfc_pkg::S_MODE && done && frm_q.addr_lw == sfc_pkg::LW4)
		|=> cont_q == ($past(byte_in[7:4]) == sfc_pkg::CONT_NIBBLE)) else $error("mode byte ignored");
	// Core checks
	a_reset_status: assert property (@(posedge clk_i) disable iff (!resetn_i)
		rs_evt |=> $stable(status_q[sfc_pkg::security_lock_bit])
		&& $stable(status_q[sfc_pkg::protect_lockdown_bit]) && !config_q[sfc_pkg::io_config_bit])
		else $error("reset status wrong");
	a_abort_busy: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(rs_evt && busy_i) |=> abort_o) else $error("abort missing");
	a_recov_long: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(rs_evt && busy_i) |=> !ready_o ##RW_DLY ready_o) else $error("recovery time wrong");
	a_erase_sector: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(erase_req_o && erase_o.kind == sfc_pkg::ER_SECTOR)
		|-> erase_o.addr[sfc_pkg::SECTOR_LSB-1:0] == '0) else $error("sector low bits kept");
	a_erase_block: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(erase_req_o && erase_o.kind == sfc_pkg::ER_BLOCK)
		|-> erase_o.addr[sfc_pkg::BLK8_LSB-1:0] == '0) else $error("block low bits kept");
	c_reset_run: cover property (@(posedge sck_i) disable iff (frame_rst) rst_go);
	c_quad_on: cover property (@(posedge sck_i) disable iff (frame_rst) opc_done && !quad_q
		&& byte_in == sfc_pkg::quad_enter_cmd);
	c_cont_frame: cover property (@(posedge sck_i) disable iff (frame_rst) cont_head);
	c_erase: cover property (@(posedge clk_i) disable iff (!resetn_i) erase_req_o);
endmodule
`default_nettype wire

//--- rtl/sfc_pkg.sv
`default_nettype none
package sfc_pkg;
	// Opcodes
	localparam logic [7:0] no_operation_cmd = 8'h00;
	localparam logic [7:0] reset_arm_cmd    = 8'h66;
	localparam logic [7:0] RESET_CMD        = 8'h99;
	localparam logic [7:0] quad_enter_cmd   = 8'h38;
	localparam logic [7:0] quad_exit_cmd    = 8'hff;
	localparam logic [7:0] READ_CMD         = 8'h03;
	localparam logic [7:0] FAST_READ_CMD    = 8'h0b;
	localparam logic [7:0] DUAL_OUT_CMD     = 8'h3b;
	localparam logic [7:0] DUAL_IO_CMD      = 8'hbb;
	localparam logic [7:0] SET_BURST_CMD    = 8'hc0;
	localparam logic [7:0] SECT_ERASE_CMD   = 8'h20;
	localparam logic [7:0] BLK_ERASE_CMD    = 8'hd8;
	localparam logic [3:0] CONT_NIBBLE      = 4'ha;
	// Phase lengths in bits
	localparam int OPC_BITS  = 8;
	localparam int ADDR_BITS = 24;
	localparam int MODE_BITS = 8;
	localparam int BYTE_BITS = 8;
	localparam int FQ_DUMMY  = 16;
	localparam int SP_DUMMY  = 8;
	// Density and erase granules
	localparam int ADDR_W     = 22;
	localparam int SECTOR_LSB = 12;
	localparam int BLK64_LSB  = 16;
	localparam int BLK32_LSB  = 15;
	localparam int BLK8_LSB   = 13;
	// Status and configuration
	localparam int protect_lockdown_bit = 4;
	localparam int security_lock_bit    = 5;
	localparam int io_config_bit        = 1;
	localparam logic [7:0] STAT_RST  = 8'h00;
	localparam logic [7:0] CFG_RST   = 8'h00;
	localparam logic [7:0] STAT_KEEP = 8'((1 << protect_lockdown_bit) | (1 << security_lock_bit));
	localparam logic [7:0] CFG_MASK  = 8'(1 << io_config_bit);
	localparam logic [1:0] BURST_RST = 2'h0;
	// Reset recovery times
	localparam int CLK_NS         = 50;
	localparam int T_RST_OTHER_NS = 1000;
	localparam int T_RST_WRITE_NS = 10000;
	localparam int RST_OTHER_CYC  = (T_RST_OTHER_NS + CLK_NS - 1) / CLK_NS;
	localparam int RST_WRITE_CYC  = (T_RST_WRITE_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [1:0] {LW1, LW2, LW4} sfc_lanes_t;
	typedef enum logic {ER_SECTOR, ER_BLOCK} sfc_erase_kind_t;
	typedef enum logic [2:0] {S_OPC, S_ADDR, S_MODE, S_DUMMY, S_DOUT, S_DIN, S_IGNORE} sfc_state_t;

	typedef struct packed {
		sfc_erase_kind_t kind;
		logic [23:0]     addr;
	} sfc_erase_t;

	typedef struct packed {
		logic       rd;
		logic       er;
		sfc_lanes_t addr_lw;
		sfc_lanes_t data_lw;
		logic       has_mode;
		logic [4:0] dummy_bits;
	} sfc_frame_t;
endpackage
`default_nettype wire

//--- rtl/sfc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module sfc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// Two-stage level synchroniser
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= d_i;
			sync_q <= meta_q;
		end
	end

	assign q_o = sync_q;
endmodule
`default_nettype wire

//--- tb/sfc_host.sv
`timescale 1ns/10ps
`default_nettype none
module sfc_host (
	output logic            sck_o,
	output logic            cs_n_o,
	output logic      [3:0] sio_o,
	input  wire logic [3:0] dev_sio_i,
	output logic      [7:0] rx_o
);
	event rx_ev;
	// Idle: clock still low, select high
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		sio_o = 4'h0;
		rx_o = 8'h00;
	end
	// Shift n bits MSB first on lw lanes, change while clock low
	task automatic put(input logic [31:0] v, input int n, input int lw);
		for (int i = n - lw; i >= 0; i -= lw) begin
			cs_n_o = 1'b0;
			if (lw == 1) sio_o = {3'($urandom), v[i]};
			else if (lw == 2) sio_o = {2'($urandom), v[i+:2]};
			else sio_o = v[i+:4];
			#40 sck_o = 1'b1;
			#40 sck_o = 1'b0;
		end
	endtask
	// Collect one byte; released lines show a changing pattern
	task automatic get(input int lw);
		logic [7:0] b;
		b = 8'h00;
		for (int i = 0; i < 8; i += lw) begin
			sio_o = ~sio_o;
			#40 sck_o = 1'b1;
			if (lw == 1) b = {b[6:0], dev_sio_i[1]};
			else if (lw == 2) b = {b[5:0], dev_sio_i[1:0]};
			else b = {b[3:0], dev_sio_i};
			#40 sck_o = 1'b0;
		end
		rx_o = b;
		->rx_ev;
	endtask
	// End of frame, clock stays still
	task automatic stop();
		#40 cs_n_o = 1'b1;
		#400;
	endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic                        clk_i = 1'b0;
	logic                        resetn_i = 1'b0;
	logic                        busy_i = 1'b0;
	logic                        stat_wr_i = 1'b0;
	logic                        cfg_wr_i = 1'b0;
	logic [7:0]                  stat_wdata_i = 8'h00;
	logic [7:0]                  cfg_wdata_i = 8'h00;
	logic                        sck, cs_n, quad, cont, ready, abort, er_req;
	logic [3:0]                  hsio, sio_out, oe_n, sio_w;
	logic [sfc_pkg::ADDR_W-1:0]  rd_addr;
	logic [7:0]                  rd_data, rx, status, cfg;
	logic [1:0]                  burst;
	sfc_pkg::sfc_erase_t         er;
	logic [7:0]                  exp_rd[$];
	sfc_pkg::sfc_erase_t         exp_er[$];
	int                          error_cnt = 0;
	int                          n_checks = 0;
	int                          ab_seen = 0;
	int                          t_oth, t_wr;
	logic [23:0]                 ea;
	logic [23:0]                 msk[5] = '{24'h3fffff, 24'h0fffff, 24'h007fff, 24'h007fff, 24'h3fffff};
	logic [23:0]                 orv[5] = '{24'h0, 24'h100000, 24'h0, 24'h008000, 24'h3f8000};
	logic [23:0]                 aln[5] = '{24'hfff, 24'hffff, 24'h1fff, 24'h7fff, 24'h1fff};
	always #25 clk_i = ~clk_i;
	// Line levels from all drivers; memory content is a fixed pattern
	assign sio_w = (oe_n & hsio) | (~oe_n & sio_out);
	assign rd_data = mem(rd_addr);
	function automatic logic [7:0] mem(input logic [sfc_pkg::ADDR_W-1:0] a);
		return a[7:0] ^ a[15:8] ^ a[21:14];
	endfunction
	sfc_cmd_ctrl uut (.clk_i(clk_i), .resetn_i(resetn_i), .sck_i(sck), .cs_n_i(cs_n),
		.sio_i(sio_w), .sio_o(sio_out), .sio_oe_n_o(oe_n), .rd_addr_o(rd_addr),
		.rd_data_i(rd_data), .quad_mode_o(quad), .cont_mode_o(cont), .burst_len_o(burst),
		.busy_i(busy_i), .stat_wr_i(stat_wr_i), .stat_wdata_i(stat_wdata_i),
		.cfg_wr_i(cfg_wr_i), .cfg_wdata_i(cfg_wdata_i), .status_o(status), .config_o(cfg),
		.ready_o(ready), .abort_o(abort), .erase_req_o(er_req), .erase_o(er));
	sfc_host u_host (.sck_o(sck), .cs_n_o(cs_n), .sio_o(hsio), .dev_sio_i(sio_w), .rx_o(rx));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_er(input sfc_pkg::sfc_erase_t e, input sfc_pkg::sfc_erase_t g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected erase expected %h seen %h", e, g);
		end
	endtask
	task automatic test_done();
		if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic cmd(input logic [7:0] op, input int lw);
		u_host.put({24'h0, op}, 8, lw);
		u_host.stop();
	endtask
	// Single-wire basic read of n bytes
	task automatic rd03(input logic [23:0] a, input int n);
		logic [sfc_pkg::ADDR_W-1:0] p;
		p = a[sfc_pkg::ADDR_W-1:0];
		for (int i = 0; i < n; i++) begin
			exp_rd.push_back(mem(p));
			p = p + 1'b1;
		end
		u_host.put({sfc_pkg::READ_CMD, a}, 32, 1);
		for (int i = 0; i < n; i++) u_host.get(1);
		u_host.stop();
	endtask
	// Quad read frame, with or without opcode, one byte
	task automatic rd0b(input logic [23:0] a, input logic [7:0] md, input logic op);
		exp_rd.push_back(mem(a[sfc_pkg::ADDR_W-1:0]));
		if (op) u_host.put({24'h0, sfc_pkg::FAST_READ_CMD}, 8, 4);
		u_host.put({8'h0, a}, 24, 4);
		u_host.put({24'h0, md}, 8, 4);
		u_host.put(32'h0, sfc_pkg::FQ_DUMMY, 4);
		u_host.get(4);
		u_host.stop();
	endtask
	// Arm and reset, then time the recovery
	task automatic rst_seq(input logic bz, input int lw, output int t);
		@(posedge clk_i);
		busy_i <= bz;
		cmd(sfc_pkg::reset_arm_cmd, lw);
		cmd(sfc_pkg::RESET_CMD, lw);
		t = 0;
		while (ready !== 1'b1 && t < 1000) begin
			@(posedge clk_i);
			t++;
		end
		if (t >= 1000) begin
			error_cnt++;
			test_done();
		end
		@(posedge clk_i);
		busy_i <= 1'b0;
	endtask
	// Result watchers
	always @(u_host.rx_ev) begin
		if (exp_rd.size() == 0) chk("rd_extra", 32'h0, 32'h1);
		else chk("rd_data", exp_rd.pop_front(), rx);
	end
	always @(posedge clk_i) begin
		if (abort === 1'b1) ab_seen <= ab_seen + 1;
		if (er_req === 1'b1 && exp_er.size() == 0) chk("er_extra", 32'h0, 32'h1);
		else if (er_req === 1'b1) chk_er(exp_er.pop_front(), er);
	end
	initial begin
		repeat (100000) @(posedge clk_i);
		error_cnt++;
		test_done();
	end
	initial begin
		void'($urandom(32'h378a));
		repeat (3) @(posedge clk_i);
		resetn_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk("ready", 32'h1, ready);
		chk("quad", 32'h0, quad);
		stat_wr_i <= 1'b1;
		stat_wdata_i <= 8'h3c;
		cfg_wr_i <= 1'b1;
		cfg_wdata_i <= 8'h06;
		@(posedge clk_i);
		stat_wr_i <= 1'b0;
		cfg_wr_i <= 1'b0;
		rd03({2'($urandom), 22'h3ffffe}, 4);
		rd03(24'($urandom) & 24'h3fffff, 2);
		// Cancelled arming leaves everything as it was
		cmd(sfc_pkg::reset_arm_cmd, 1);
		cmd(sfc_pkg::no_operation_cmd, 1);
		cmd(sfc_pkg::RESET_CMD, 1);
		chk("ready", 32'h1, ready);
		chk("status", 32'h3c, status);
		rst_seq(1'b0, 1, t_oth);
		chk("status", (sfc_pkg::STAT_RST & ~sfc_pkg::STAT_KEEP) | (8'h3c & sfc_pkg::STAT_KEEP), status);
		chk("config", 8'h06 & ~sfc_pkg::CFG_MASK, cfg);
		chk("burst", sfc_pkg::BURST_RST, burst);
		chk("recov", 32'h1, t_oth > 0);
		cmd(sfc_pkg::quad_enter_cmd, 1);
		chk("quad", 32'h1, quad);
		u_host.put({sfc_pkg::READ_CMD, 24'h0}, 32, 4);
		u_host.put(32'h0, 16, 4);
		chk("oe_n", 32'hf, oe_n);
		u_host.stop();
		ea = 24'($urandom) & 24'h3fffff;
		rd0b(ea, 8'ha5, 1'b1);
		chk("cont", 32'h1, cont);
		rd0b(ea + 24'h100, 8'ha0, 1'b0);
		cmd(sfc_pkg::quad_exit_cmd, 4);
		chk("cont", 32'h0, cont);
		chk("quad", 32'h1, quad);
		cmd(sfc_pkg::quad_exit_cmd, 4);
		chk("quad", 32'h0, quad);
		cmd(sfc_pkg::quad_exit_cmd, 1);
		chk("quad", 32'h0, quad);
		rd03(ea, 1);
		cmd(sfc_pkg::quad_enter_cmd, 1);
		rst_seq(1'b1, 4, t_wr);
		chk("quad", 32'h0, quad);
		chk("abort", 32'h1, ab_seen);
		chk("recov_long", 32'h1, t_wr > t_oth);
		// Dual-output read: single address, one dummy byte, two lanes out
		exp_rd.push_back(mem(ea[sfc_pkg::ADDR_W-1:0]));
		u_host.put({sfc_pkg::DUAL_OUT_CMD, ea}, 32, 1);
		u_host.put(32'h0, sfc_pkg::SP_DUMMY, 1);
		u_host.get(2);
		u_host.stop();
		// Sector and block erase base addresses across regions
		for (int k = 0; k < 5; k++) begin
			ea = (24'($urandom) & msk[k]) | orv[k];
			exp_er.push_back('{(k == 0) ? sfc_pkg::ER_SECTOR : sfc_pkg::ER_BLOCK, ea & ~aln[k]});
			u_host.put({(k == 0) ? sfc_pkg::SECT_ERASE_CMD : sfc_pkg::BLK_ERASE_CMD, ea}, 32, 1);
			u_host.stop();
		end
		repeat (20) @(posedge clk_i);
		chk("rd_left", 32'h0, exp_rd.size());
		chk("er_left", 32'h0, exp_er.size());
		test_done();
	end
endmodule
`default_nettype wire
